// ==== design/timer16_pkg.sv ====
package timer16_pkg;

	// =====================================================
	// widths and reset values
	localparam int          COUNT_W    = 16;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] CCR_RESET  = 16'h0000;

	// =====================================================
	// field positions inside prescale_mode0
	localparam int CLK_SEL_LSB   = 0;
	localparam int EDGE_SEL0_LSB = 4;
	localparam int EDGE_SEL1_LSB = 6;

	// =====================================================
	// count clock divider
	localparam int          DIV_W      = 3;
	localparam logic [2:0]  DIV_RESET  = 3'h0;

	// =====================================================
	// enumerations
	typedef enum logic [1:0] {
		RUN_STOP,
		RUN_FREE,
		RUN_TRIG_CLR,
		RUN_MATCH_CLR
	} run_mode_type;

	typedef enum logic [1:0] {
		EDGE_FALL,
		EDGE_RISE,
		EDGE_NONE,
		EDGE_BOTH
	} edge_sel_type;

	typedef enum logic [1:0] {
		CLK_DIV2,
		CLK_DIV4,
		CLK_DIV8,
		CLK_TRIG0
	} clk_sel_type;

	// =====================================================
	// control bundle
	typedef struct packed {
		logic cr0_capture;
		logic cr0_trig_inv;
		logic cr1_capture;
	} cap_cmp_ctrl_type;

	typedef struct packed {
		logic out_en;
		logic oneshot_en;
	} output_ctrl_type;

	typedef struct packed {
		run_mode_type     run_mode_bits;
		cap_cmp_ctrl_type cap_cmp_ctrl;
		output_ctrl_type  output_ctrl;
	} ctrl_type;

endpackage

// ==== design/count_clock_gen.sv ====
`timescale 1ns/100ps
`default_nettype none

module count_clock_gen
	import timer16_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       reset_in,
	// selection
	input  wire logic [1:0] clk_sel_in,
	// ticks
	output logic            half_tick_out,
	output logic            rise_tick_out,
	output logic            fall_tick_out
);

	// =====================================================
	// free running divider
	// runs regardless of the timer so a start lands anywhere in a period
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] mask;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			div_ff <= DIV_RESET;
		end else begin
			div_ff <= div_ff + 3'h1;
		end
	end

	always_comb begin
		case (clk_sel_in)
			2'h0:    mask = 3'h1;
			2'h1:    mask = 3'h3;
			default: mask = 3'h7;
		endcase
	end

	// =====================================================
	// tick decode
	assign half_tick_out = div_ff[0];
	assign rise_tick_out = (div_ff & mask) == mask;
	assign fall_tick_out = (div_ff & mask) == (mask >> 1);

endmodule

`default_nettype wire

// ==== design/trig_edge_filter.sv ====
`timescale 1ns/100ps
`default_nettype none

module trig_edge_filter (
	// clock and reset
	input  wire logic clk_sys_in,
	input  wire logic reset_in,
	// pin and sampling
	input  wire logic pin_in,
	input  wire logic sample_in,
	input  wire logic enable_in,
	// accepted edges
	output logic      rise_out,
	output logic      fall_out
);

	// =====================================================
	// two equal samples before a level is accepted
	logic samp_ff;
	logic level_ff;
	logic seen_ff;
	logic accept;

	assign accept = sample_in && (pin_in == samp_ff) && (pin_in != level_ff);

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			samp_ff <= 1'b0;
		end else if (sample_in) begin
			samp_ff <= pin_in;
		end
	end

	// level stays low until first enable, so a high pin then reads as rise
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			seen_ff  <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			if (enable_in) begin
				seen_ff <= 1'b1;
			end
			if (accept && (enable_in || seen_ff)) begin // R21
				level_ff <= pin_in;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			rise_out <= accept && enable_in && pin_in; // R14 R22
			fall_out <= accept && enable_in && !pin_in;
		end
	end

endmodule

`default_nettype wire

// ==== design/timer16_core.sv ====
// Function
// R1: counter halts while run mode is zero, counts at once otherwise.
// R2: first match after start may lag by up to one count clock.
// R3: software loads both compare registers nonzero in match-clear mode.
// R4: compare lowered below count: count on, wrap, restart from zero.
// R5: software stops and restarts after lowering compare register zero.
// R6: capture beats a coincident read; read value undefined; interrupt raised.
// R7: software stops the timer before changing edge selection.
// R8: software does not retrigger software pulse while pulse is active.
// R9: external edge during pulse clears counter and restarts the pulse.
// R10: external trigger still works in software one-shot operation.
// R11: wrap flag also set on match clear from FFFF to zero.
// R12: wrap flag clear before next count clock is overridden.
// R13: reading the counter causes no capture into register one.
// R14: trigger pin edges ignored while the timer is stopped.
// R15: one-shot only in free-running or edge clear-and-start modes.
// R16: capture on trigger zero unusable when it is the count clock.
// R17: both edges plus inverse-phase capture trigger gives no capture.
// R18: capture pulses must last over two count clock periods.
// R19: capture on count clock fall, interrupt on following rise.
// R20: register in compare mode ignores capture triggers.
// R21: pin high after reset gives rising edge on first enable only.
// R22: count edge sampled at half rate, capture at count clock, twice.
// R23: prescale bits four and five choose the trigger zero edge.
// R24: software trigger clears, starts, pulse on smaller match, off larger.
`timescale 1ns/100ps
`default_nettype none

module timer16_core
	import timer16_pkg::*;
#(
	parameter int CW = COUNT_W
) (
	// clock and reset
	input  wire logic          clk_sys_in,
	input  wire logic          reset_in,
	// configuration
	input  wire ctrl_type      ctrl_in,
	input  wire logic [7:0]    prescale_mode0_in,
	// software strobes
	input  wire logic          soft_pulse_trigger_in,
	input  wire logic          wr_cr0_in,
	input  wire logic          wr_cr1_in,
	input  wire logic [CW-1:0] wr_data_in,
	input  wire logic          rd_cr0_in,
	input  wire logic          rd_cr1_in,
	input  wire logic          clr_wrap_in,
	// pins
	input  wire logic          trig_in0,
	input  wire logic          trig_in1,
	// status and data
	output logic [CW-1:0]      timer_count_out,
	output logic [CW-1:0]      cap_cmp_reg0_out,
	output logic [CW-1:0]      cap_cmp_reg1_out,
	output logic [CW-1:0]      rd_data_out,
	output logic               wrap_flag_out,
	output logic               match_irq0_out,
	output logic               match_irq1_out,
	output logic               pulse_out
);

	// =====================================================
	// decode
	function automatic logic edge_hit(input edge_sel_type sel,
	                                  input logic rise, input logic fall);
		case (sel)
			EDGE_FALL: edge_hit = fall;
			EDGE_RISE: edge_hit = rise;
			EDGE_BOTH: edge_hit = rise | fall;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	run_mode_type     mode;
	edge_sel_type     esel0;
	edge_sel_type     esel1;
	clk_sel_type      csel;
	cap_cmp_ctrl_type cc;
	logic             running;

	assign mode    = ctrl_in.run_mode_bits;
	assign cc      = ctrl_in.cap_cmp_ctrl;
	assign esel0   = edge_sel_type'(prescale_mode0_in[EDGE_SEL0_LSB +: 2]); // R23
	assign esel1   = edge_sel_type'(prescale_mode0_in[EDGE_SEL1_LSB +: 2]);
	assign csel    = clk_sel_type'(prescale_mode0_in[CLK_SEL_LSB +: 2]);
	assign running = mode != RUN_STOP; // R1

	// =====================================================
	// count clock and pin filters
	logic half_tick;
	logic rise_tick;
	logic fall_tick;
	logic cnt_rise;
	logic cnt_fall;
	logic t0_rise;
	logic t0_fall;
	logic t1_rise;
	logic t1_fall;

	count_clock_gen u_clk (
		.clk_sys_in    (clk_sys_in),
		.reset_in      (reset_in),
		.clk_sel_in    (prescale_mode0_in[CLK_SEL_LSB +: 2]),
		.half_tick_out (half_tick),
		.rise_tick_out (rise_tick),
		.fall_tick_out (fall_tick)
	);

	// count edge filter samples at half the system rate
	trig_edge_filter u_cnt_edge (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.pin_in     (trig_in0),
		.sample_in  (half_tick), // R22
		.enable_in  (running),
		.rise_out   (cnt_rise),
		.fall_out   (cnt_fall)
	);

	// capture filters sample at the selected count clock
	trig_edge_filter u_t0_edge (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.pin_in     (trig_in0),
		.sample_in  (fall_tick), // R22
		.enable_in  (running),
		.rise_out   (t0_rise),
		.fall_out   (t0_fall)
	);

	trig_edge_filter u_t1_edge (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.pin_in     (trig_in1),
		.sample_in  (fall_tick),
		.enable_in  (running),
		.rise_out   (t1_rise),
		.fall_out   (t1_fall)
	);

	// =====================================================
	// events
	logic          ext_clk;
	logic          tick;
	logic          t0_valid;
	logic          t0_inverse;
	logic          t1_valid;
	logic          cap0_trig;
	logic          cap1_trig;
	logic          oneshot_ok;
	logic          restart;
	logic          match0;
	logic          match1;
	logic          match_clr;
	logic          overflow;
	logic [CW-1:0] pulse_on;
	logic [CW-1:0] pulse_off;

	assign ext_clk    = csel == CLK_TRIG0;
	assign tick       = running && (ext_clk ? edge_hit(esel0, cnt_rise, cnt_fall)
	                                        : rise_tick);
	assign t0_valid   = edge_hit(esel0, t0_rise, t0_fall);
	assign t1_valid   = edge_hit(esel1, t1_rise, t1_fall);
	// inverse phase of a both-edge selection is empty
	assign t0_inverse = (esel0 == EDGE_RISE) ? t0_fall
	                  : (esel0 == EDGE_FALL) ? t0_rise : 1'b0; // R17
	// trigger zero as count clock leaves its capture unusable
	assign cap0_trig  = cc.cr0_capture && (cc.cr0_trig_inv ?
	                    (t0_inverse && !ext_clk) : t1_valid); // R16 R20
	assign cap1_trig  = cc.cr1_capture && t0_valid && !ext_clk; // R16 R20
	assign oneshot_ok = ctrl_in.output_ctrl.oneshot_en &&
	                    (mode == RUN_FREE || mode == RUN_TRIG_CLR); // R15
	// external edge retriggers even in software one-shot use
	assign restart    = running && ((mode == RUN_TRIG_CLR && t0_valid) ||
	                    (oneshot_ok && (soft_pulse_trigger_in || t0_valid))); // R9 R10 R24
	assign match0     = timer_count_out == cap_cmp_reg0_out;
	assign match1     = timer_count_out == cap_cmp_reg1_out;
	// only equality clears, so a lowered compare lets the count wrap
	assign match_clr  = mode == RUN_MATCH_CLR && match0 && !cc.cr0_capture; // R4
	assign overflow   = tick && !restart && timer_count_out == CW'(COUNT_MAX);
	assign pulse_on   = (cap_cmp_reg1_out < cap_cmp_reg0_out) ?
	                    cap_cmp_reg1_out : cap_cmp_reg0_out; // R24
	assign pulse_off  = (cap_cmp_reg1_out < cap_cmp_reg0_out) ?
	                    cap_cmp_reg0_out : cap_cmp_reg1_out;

	// =====================================================
	// counter
	logic [CW-1:0] count_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			count_ff <= CW'(COUNT_ZERO);
		end else if (!running) begin
			count_ff <= CW'(COUNT_ZERO); // R1
		end else if (restart) begin
			count_ff <= CW'(COUNT_ZERO); // R9
		end else if (tick) begin
			// prescaler free-runs, so first tick lags up to one period
			if (match_clr) begin // R2
				count_ff <= CW'(COUNT_ZERO);
			end else begin
				count_ff <= count_ff + CW'(16'h0001);
			end
		end
	end
	assign timer_count_out = count_ff; // R13

	// =====================================================
	// capture/compare registers, capture over write
	logic [CW-1:0] cr0_ff;
	logic [CW-1:0] cr1_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			cr0_ff <= CW'(CCR_RESET);
		end else if (cap0_trig) begin
			cr0_ff <= count_ff; // R19 R20
		end else if (wr_cr0_in) begin
			cr0_ff <= wr_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			cr1_ff <= CW'(CCR_RESET);
		end else if (cap1_trig) begin
			cr1_ff <= count_ff; // R6 R19
		end else if (wr_cr1_in) begin
			cr1_ff <= wr_data_in;
		end
	end
	assign cap_cmp_reg0_out = cr0_ff;
	assign cap_cmp_reg1_out = cr1_ff;

	// read path samples the old value; capture still lands
	logic [CW-1:0] rd_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rd_ff <= CW'(CCR_RESET);
		end else if (rd_cr0_in) begin
			rd_ff <= cr0_ff; // R6
		end else if (rd_cr1_in) begin
			rd_ff <= cr1_ff;
		end
	end
	assign rd_data_out = rd_ff;

	// =====================================================
	// interrupts: capture held until next count clock rise
	logic cap0_pend_ff;
	logic cap1_pend_ff;
	logic irq0_ff;
	logic irq1_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			cap0_pend_ff <= 1'b0;
			cap1_pend_ff <= 1'b0;
		end else begin
			cap0_pend_ff <= cap0_trig || (cap0_pend_ff && !rise_tick);
			cap1_pend_ff <= cap1_trig || (cap1_pend_ff && !rise_tick); // R6
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			irq0_ff <= 1'b0;
			irq1_ff <= 1'b0;
		end else begin
			irq0_ff <= (cap0_pend_ff && rise_tick) ||
			           (tick && match0 && !cc.cr0_capture); // R19
			irq1_ff <= (cap1_pend_ff && rise_tick) ||
			           (tick && match1 && !cc.cr1_capture); // R19
		end
	end
	assign match_irq0_out = irq0_ff;
	assign match_irq1_out = irq1_ff;

	// =====================================================
	// wrap flag; set wins, and stays until the next count clock, restart or stop
	logic wrap_ff;
	logic wrap_hold_ff;
	logic wrap_set;

	assign wrap_set = overflow ||
	                  (tick && match_clr && cr0_ff == CW'(COUNT_MAX)); // R11

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			wrap_hold_ff <= 1'b0;
		end else if (wrap_set) begin
			wrap_hold_ff <= 1'b1;
		end else if (tick || restart || !running) begin
			wrap_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			wrap_ff <= 1'b0;
		end else begin
			wrap_ff <= wrap_set || wrap_hold_ff ||
			           (wrap_ff && !clr_wrap_in); // R12
		end
	end
	assign wrap_flag_out = wrap_ff;

	// =====================================================
	// one-shot pulse
	logic pulse_ff;
	logic armed_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			armed_ff <= 1'b0;
			pulse_ff <= 1'b0;
		end else if (!running || !oneshot_ok) begin
			armed_ff <= 1'b0; // R15
			pulse_ff <= 1'b0;
		end else if (restart) begin
			armed_ff <= 1'b1; // R9 R24
			pulse_ff <= 1'b0;
		end else if (tick && armed_ff) begin
			if (count_ff == pulse_off) begin
				armed_ff <= 1'b0;
				pulse_ff <= 1'b0;
			end else if (count_ff == pulse_on) begin
				pulse_ff <= ctrl_in.output_ctrl.out_en; // R24
			end
		end
	end
	assign pulse_out = pulse_ff;

endmodule

`default_nettype wire

// ==== bench/trig_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// =====================================
// trigger pin source
module trig_pin_model #(
	parameter int HOLD = 20
) (
	// clock
	input  wire logic       clk_sys_in,
	// requests
	input  wire logic [1:0] fire_in,
	// pins
	output logic [1:0]      pins_out
);
	int left [2] = '{0, 0};

	// long pulses, so a slow count clock still samples them twice
	always @(posedge clk_sys_in) begin
		for (int i = 0; i < 2; i++) begin
			if (fire_in[i]) begin
				left[i] <= HOLD;
			end else if (left[i] > 0) begin
				left[i] <= left[i] - 1;
			end
		end
	end
	assign pins_out = {left[1] > 0, left[0] > 0};
endmodule

`default_nettype wire

// ==== bench/timer16_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

// =====================================
// port checker
module timer16_chk
	import timer16_pkg::*;
#(
	parameter int CW = COUNT_W
) (
	// clock and reset
	input  wire logic          clk_sys_in,
	input  wire logic          reset_in,
	// control
	input  wire ctrl_type      ctrl_in,
	input  wire logic [7:0]    prescale_mode0_in,
	input  wire logic          wr_cr0_in,
	input  wire logic          wr_cr1_in,
	input  wire logic          clr_wrap_in,
	// results
	input  wire logic [CW-1:0] timer_count_out,
	input  wire logic [CW-1:0] cap_cmp_reg0_out,
	input  wire logic [CW-1:0] cap_cmp_reg1_out,
	input  wire logic          wrap_flag_out,
	input  wire logic          match_irq1_out,
	input  wire logic          pulse_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	logic [CW-1:0] lo_cmp;
	logic          run_free;
	assign lo_cmp = (cap_cmp_reg0_out < cap_cmp_reg1_out) ?
		cap_cmp_reg0_out : cap_cmp_reg1_out;
	assign run_free = ctrl_in.run_mode_bits == RUN_FREE;

	property p_stop_zero;
		(ctrl_in.run_mode_bits == RUN_STOP)[*2] |-> timer_count_out == '0;
	endproperty
	a_stop_zero: assert property (p_stop_zero)
		else $error("count moved while stopped");

	property p_step;
		timer_count_out != $past(timer_count_out) |->
			timer_count_out == $past(timer_count_out) + 1'b1 ||
			timer_count_out == '0;
	endproperty
	a_step: assert property (p_step)
		else $error("count jumped");

	property p_wrap_set;
		(run_free || ctrl_in.run_mode_bits == RUN_MATCH_CLR) &&
		$past(timer_count_out) == '1 && timer_count_out == '0 |->
			##[0:1] wrap_flag_out;
	endproperty
	a_wrap_set: assert property (p_wrap_set)
		else $error("wrap flag missing");

	property p_wrap_hold;
		run_free && timer_count_out == '0 && wrap_flag_out && clr_wrap_in
			|=> wrap_flag_out;
	endproperty
	a_wrap_hold: assert property (p_wrap_hold)
		else $error("early wrap clear took effect");

	property p_cr1_hold;
		!ctrl_in.cap_cmp_ctrl.cr1_capture && !wr_cr1_in |=>
			$stable(cap_cmp_reg1_out);
	endproperty
	a_cr1_hold: assert property (p_cr1_hold)
		else $error("compare register one changed");

	property p_cr0_inv;
		ctrl_in.cap_cmp_ctrl.cr0_capture && ctrl_in.cap_cmp_ctrl.cr0_trig_inv
		&& prescale_mode0_in[5:4] == 2'h3 && !wr_cr0_in |=>
			$stable(cap_cmp_reg0_out);
	endproperty
	a_cr0_inv: assert property (p_cr0_inv)
		else $error("inverse capture happened");

	property p_pulse_rise;
		$rose(pulse_out) |-> ctrl_in.output_ctrl.oneshot_en &&
			ctrl_in.run_mode_bits inside {RUN_FREE, RUN_TRIG_CLR} &&
			$past(timer_count_out) == lo_cmp;
	endproperty
	a_pulse_rise: assert property (p_pulse_rise)
		else $error("pulse started at wrong point");

	property p_cap_irq;
		ctrl_in.cap_cmp_ctrl.cr1_capture && !$past(wr_cr1_in) &&
		$changed(cap_cmp_reg1_out) |-> ##[0:9] match_irq1_out;
	endproperty
	a_cap_irq: assert property (p_cap_irq)
		else $error("capture without interrupt");

	c_wrap: cover property ($rose(wrap_flag_out));
	c_pulse: cover property ($fell(pulse_out));
	c_irq: cover property (match_irq1_out);
endmodule

bind timer16_core timer16_chk #(.CW(CW)) u_chk (.clk_sys_in, .reset_in,
	.ctrl_in, .prescale_mode0_in, .wr_cr0_in, .wr_cr1_in, .clr_wrap_in,
	.timer_count_out, .cap_cmp_reg0_out, .cap_cmp_reg1_out,
	.wrap_flag_out, .match_irq1_out, .pulse_out);

`default_nettype wire

// ==== bench/timer16_capture_oneshot_rules_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
`define WAIT(c, n) repeat (n) begin if (c) break; @(posedge clk_sys_in); #1; end

// =====================================
// bench top
module timer16_capture_oneshot_rules_tb
	import timer16_pkg::*;
;
	localparam int CW = 8;
	logic clk_sys_in = 0, reset_in = 1, soft_pulse_trigger_in = 0;
	logic wr_cr0_in = 0, wr_cr1_in = 0, clr_wrap_in = 0, rd_cr1_in = 0;
	logic [1:0] fire = '0;
	ctrl_type ctrl_in = '0;
	logic [7:0] prescale_mode0_in = '0;
	logic [CW-1:0] wr_data_in = '0;
	wire logic trig_in0, trig_in1;
	logic [CW-1:0] timer_count_out, cap_cmp_reg0_out, cap_cmp_reg1_out;
	logic [CW-1:0] rd_data_out;
	logic wrap_flag_out, match_irq0_out, match_irq1_out, pulse_out, seen;
	int n_fail = 0, total_checks = 0;

	// read of register zero tied off; register one covers the conflict
	timer16_core #(.CW(CW)) DUT (.clk_sys_in, .reset_in, .ctrl_in,
		.prescale_mode0_in, .soft_pulse_trigger_in, .wr_cr0_in, .wr_cr1_in,
		.wr_data_in, .rd_cr0_in(1'b0), .rd_cr1_in, .clr_wrap_in,
		.trig_in0, .trig_in1, .timer_count_out, .cap_cmp_reg0_out,
		.cap_cmp_reg1_out, .rd_data_out, .wrap_flag_out,
		.match_irq0_out, .match_irq1_out, .pulse_out);
	trig_pin_model u_pins (.clk_sys_in, .fire_in(fire),
		.pins_out({trig_in1, trig_in0}));

	initial forever #10 clk_sys_in = ~clk_sys_in;

	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic strobe(input int which);
		@(posedge clk_sys_in);
		if (which == 2) soft_pulse_trigger_in <= 1'b1;
		else if (which == 3) clr_wrap_in <= 1'b1;
		else fire[which] <= 1'b1;
		@(posedge clk_sys_in);
		soft_pulse_trigger_in <= 1'b0;
		clr_wrap_in <= 1'b0;
		fire <= '0;
		#1;
	endtask

	// stop first: edge selection must not change while running
	task automatic cfg(input run_mode_type m, input logic [7:0] p,
		input logic [2:0] c, input logic [1:0] o,
		input logic [CW-1:0] v0, input logic [CW-1:0] v1);
		@(posedge clk_sys_in);
		ctrl_in.run_mode_bits <= RUN_STOP;
		@(posedge clk_sys_in);
		prescale_mode0_in <= p;
		ctrl_in.cap_cmp_ctrl <= c;
		ctrl_in.output_ctrl <= o;
		wr_cr0_in <= 1'b1;
		wr_data_in <= v0;
		@(posedge clk_sys_in);
		wr_cr0_in <= 1'b0;
		wr_cr1_in <= 1'b1;
		wr_data_in <= v1;
		@(posedge clk_sys_in);
		wr_cr1_in <= 1'b0;
		ctrl_in.run_mode_bits <= m;
		#1;
	endtask

	task automatic t_stop;
		strobe(0);
		strobe(1);
		repeat (30) @(posedge clk_sys_in);
		#1;
		`CHK(timer_count_out, 8'h00)
		`CHK(cap_cmp_reg1_out, 8'h00)
		cfg(RUN_FREE, 8'h10, 3'h0, 2'h0, 8'h30, 8'h40);
		repeat (5) @(posedge clk_sys_in);
		#1;
		`CHK(timer_count_out > 0 && timer_count_out < 4, 1'b1)
	endtask

	task automatic t_wrap;
		cfg(RUN_FREE, 8'h12, 3'h0, 2'h0, 8'h30, 8'h40);
		`WAIT(timer_count_out == 8'hFF, 2100)
		`WAIT(timer_count_out == 8'h00, 20)
		strobe(3);
		`CHK(wrap_flag_out, 1'b1)
		`WAIT(timer_count_out == 8'h01, 20)
		strobe(3);
		`CHK(wrap_flag_out, 1'b0)
		cfg(RUN_MATCH_CLR, 8'h12, 3'h0, 2'h0, 8'hFF, 8'hFF);
		`WAIT(timer_count_out == 8'hFF, 2100)
		`WAIT(match_irq0_out, 20)
		`CHK(match_irq0_out, 1'b1)
		`WAIT(timer_count_out == 8'h00, 20)
		`WAIT(wrap_flag_out, 3)
		`CHK(wrap_flag_out, 1'b1)
	endtask

	task automatic t_oneshot;
		cfg(RUN_FREE, 8'h10, 3'h0, 2'h3, 8'h14, 8'h0A);
		strobe(2);
		`WAIT(pulse_out, 60)
		`CHK(timer_count_out >= 8'h0A && timer_count_out <= 8'h0C, 1'b1)
		`WAIT(!pulse_out, 60)
		`CHK(timer_count_out >= 8'h14 && timer_count_out <= 8'h16, 1'b1)
		strobe(2);
		`WAIT(pulse_out, 60)
		strobe(0);
		`WAIT(timer_count_out < 8'h04, 20)
		`CHK(timer_count_out < 8'h04, 1'b1)
		`WAIT(pulse_out, 60)
		`CHK(pulse_out, 1'b1)
		cfg(RUN_MATCH_CLR, 8'h10, 3'h0, 2'h3, 8'h14, 8'h0A);
		strobe(2);
		seen = 1'b0;
		repeat (100) begin
			@(posedge clk_sys_in);
			#1;
			seen |= pulse_out;
		end
		`CHK(seen, 1'b0)
		cfg(RUN_TRIG_CLR, 8'h10, 3'h0, 2'h3, 8'h14, 8'h0A);
		repeat (20) @(posedge clk_sys_in);
		strobe(0);
		`WAIT(timer_count_out < 8'h04, 20)
		`CHK(timer_count_out < 8'h04, 1'b1)
		`WAIT(pulse_out, 60)
		`CHK(pulse_out, 1'b1)
	endtask

	task automatic t_capture;
		cfg(RUN_FREE, 8'h10, 3'h1, 2'h0, 8'h30, 8'h33);
		repeat (20) @(posedge clk_sys_in);
		rd_cr1_in <= 1'b1;
		strobe(0);
		`WAIT(match_irq1_out, 40)
		`CHK(match_irq1_out, 1'b1)
		`CHK(cap_cmp_reg1_out != 8'h33, 1'b1)
		@(posedge clk_sys_in);
		rd_cr1_in <= 1'b0;
		repeat (30) @(posedge clk_sys_in);
		cfg(RUN_FREE, 8'h10, 3'h0, 2'h0, 8'h30, 8'h33);
		strobe(0);
		repeat (30) @(posedge clk_sys_in);
		#1;
		`CHK(cap_cmp_reg1_out, 8'h33)
		@(posedge clk_sys_in);
		rd_cr1_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_cr1_in <= 1'b0;
		#1;
		`CHK(rd_data_out, 8'h33)
		cfg(RUN_FREE, 8'h30, 3'h6, 2'h0, 8'h44, 8'h33);
		strobe(0);
		repeat (40) @(posedge clk_sys_in);
		#1;
		`CHK(cap_cmp_reg0_out, 8'h44)
		cfg(RUN_FREE, 8'h13, 3'h1, 2'h0, 8'h30, 8'h33);
		strobe(0);
		repeat (30) @(posedge clk_sys_in);
		#1;
		`CHK(cap_cmp_reg1_out, 8'h33)
		`CHK(timer_count_out, 8'h01)
	endtask

	initial begin
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		`CHK(timer_count_out, 8'h00)
		`CHK(pulse_out, 1'b0)
		t_stop();
		t_wrap();
		t_oneshot();
		t_capture();
		end_sim();
	end

	// whole run needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		end_sim();
	end
endmodule

`default_nettype wire
